// *** design/sensor_divider_params.svh ***
// Overview of operation
// - Input divider 15:12 divides sensor frequency; zero reserved
// - Reference divider 9:0 divides master clock; zero reserved
// - Status 15:14 names channel of latched error
// - Error held until status or source result read
// - Status bit 13 flags under-range error
// - Status bit 12 flags over-range error
// - Status bit 11 flags watchdog timeout error
// - Bits 10/9 flag amplitude high/low errors
// - Status bit 8 flags zero-count error
// - Bit 6 ready: single conversion or full sequence
// - Bits 3..0 flag unread results, cleared by reading
// - Status read clears errors; fields read-only, reset zero
// - Settle 32 ref cycles if count<=1, else count*16
`ifndef SENSOR_DIVIDER_PARAMS_SVH
`define SENSOR_DIVIDER_PARAMS_SVH

`define NUM_CHANNELS 4
`define ADDR_SETTLE_CH3 8'h13
`define ADDR_DIV_CH0 8'h14
`define ADDR_DIV_CH1 8'h15
`define ADDR_DIV_CH2 8'h16
`define ADDR_DIV_CH3 8'h17
`define ADDR_STATUS 8'h18
`define FIN_DIV_HI 15
`define FIN_DIV_LO 12
`define FREF_DIV_HI 9
`define FREF_DIV_LO 0
`define DIV_RESET 16'h0000
`define SETTLE_RESET 16'h0000
`define SETTLE_MIN_TICKS 20'h00020
`define SETTLE_SHORT_LIMIT 16'h0001
`define SETTLE_TICK_SHIFT 4
`define ERROR_SOURCE_CHANNEL_RESET 2'h0

`endif

// *** design/sensor_divider_pkg.sv ***
`include "sensor_divider_params.svh"

package sensor_divider_pkg;

    typedef enum logic [0:0] {
        SETTLE_IDLE = 1'b0,
        SETTLE_RUN = 1'b1
    } settle_state_type;

    // Error flags in status order: under, over, timeout, amp high, amp low, zero
    typedef struct packed {
        logic [`NUM_CHANNELS-1:0][15:0] div;
        logic [15:0] settle;
        logic [1:0] error_source_channel;
        logic [5:0] err_flags;
        logic result_ready_flag;
        logic [`NUM_CHANNELS-1:0] unread;
        logic [`NUM_CHANNELS-1:0] seq_done;
        settle_state_type settle_st;
        logic [19:0] settle_left;
        logic settle_done;
        logic [15:0] rdata;
        logic rvalid;
    } regs_type;

    typedef struct packed {
        logic sensor_prev;
        logic [3:0] fin_cnt;
        logic [9:0] ref_cnt;
        logic sensor_tick;
        logic ref_tick;
    } div_state_type;

endpackage

// *** design/channel_clock_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sensor_divider_params.svh"

module channel_clock_divider (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sensor_in,
    input wire logic [3:0] fin_div,
    input wire logic [9:0] fref_div,
    output logic sensor_tick,
    output logic ref_tick
);

    sensor_divider_pkg::div_state_type s_q;
    sensor_divider_pkg::div_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.sensor_prev = sensor_in;
        s_d.sensor_tick = 1'b0;
        s_d.ref_tick = 1'b0;
        // Reserved zero behaves as divide by one
        if (sensor_in && !s_q.sensor_prev) begin
            if (s_q.fin_cnt + 4'h1 >= fin_div) begin
                s_d.fin_cnt = 4'h0;
                s_d.sensor_tick = 1'b1;
            end else begin
                s_d.fin_cnt = s_q.fin_cnt + 4'h1;
            end
        end
        if (s_q.ref_cnt + 10'h001 >= fref_div) begin
            s_d.ref_cnt = 10'h000;
            s_d.ref_tick = 1'b1;
        end else begin
            s_d.ref_cnt = s_q.ref_cnt + 10'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sensor_tick = s_q.sensor_tick;
    assign ref_tick = s_q.ref_tick;

endmodule

`default_nettype wire

// *** design/sensor_divider_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sensor_divider_params.svh"

module sensor_divider_status_regs #(
    parameter int NCH = `NUM_CHANNELS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic [5:0] err_event,
    input wire logic [1:0] err_event_channel,
    input wire logic conv_done,
    input wire logic [1:0] conv_channel,
    input wire logic sequential_mode,
    input wire logic [NCH-1:0] active_channels,
    input wire logic [NCH-1:0] result_read,
    input wire logic settle_start,
    output logic settle_done,
    input wire logic [NCH-1:0] sensor_in,
    output logic [NCH-1:0] sensor_tick,
    output logic [NCH-1:0] ref_tick
);

    sensor_divider_pkg::regs_type r_q;
    sensor_divider_pkg::regs_type r_d;

    logic status_read;
    logic [15:0] status_word;
    logic [NCH-1:0] done_mask;
    logic [NCH-1:0] done_accum;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel dividers

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_div
            channel_clock_divider u_div (
                .mclk(mclk),
                .rst_n(rst_n),
                .sensor_in(sensor_in[ch]),
                .fin_div(r_q.div[ch][`FIN_DIV_HI:`FIN_DIV_LO]),
                .fref_div(r_q.div[ch][`FREF_DIV_HI:`FREF_DIV_LO]),
                .sensor_tick(sensor_tick[ch]),
                .ref_tick(ref_tick[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Status word and read side effects

    always_comb begin
        status_word = 16'h0000;
        status_word[15:14] = r_q.error_source_channel;
        status_word[13:8] = r_q.err_flags;
        status_word[6] = r_q.result_ready_flag;
        // Channel 0 sits in the highest unread bit
        for (int i = 0; i < NCH; i++) begin
            status_word[NCH-1-i] = r_q.unread[i];
        end
    end

    assign status_read = reg_rd_en && (reg_addr == `ADDR_STATUS);
    assign done_mask = conv_done ? (NCH'(1) << conv_channel) : '0;
    assign done_accum = r_q.seq_done | done_mask;

    always_comb begin
        r_d = r_q;
        r_d.rvalid = reg_rd_en;
        r_d.settle_done = 1'b0;

        // Register writes; status is read-only
        if (reg_wr_en) begin
            case (reg_addr)
                `ADDR_SETTLE_CH3: r_d.settle = reg_wdata;
                `ADDR_DIV_CH0: r_d.div[0] = reg_wdata;
                `ADDR_DIV_CH1: r_d.div[1] = reg_wdata;
                `ADDR_DIV_CH2: r_d.div[2] = reg_wdata;
                `ADDR_DIV_CH3: r_d.div[3] = reg_wdata;
                default: r_d.settle = r_q.settle;
            endcase
        end

        if (reg_rd_en) begin
            case (reg_addr)
                `ADDR_SETTLE_CH3: r_d.rdata = r_q.settle;
                `ADDR_DIV_CH0: r_d.rdata = r_q.div[0];
                `ADDR_DIV_CH1: r_d.rdata = r_q.div[1];
                `ADDR_DIV_CH2: r_d.rdata = r_q.div[2];
                `ADDR_DIV_CH3: r_d.rdata = r_q.div[3];
                `ADDR_STATUS: r_d.rdata = status_word;
                default: r_d.rdata = 16'h0000;
            endcase
        end

        // Clears first so a same-cycle event wins
        if (status_read) begin
            r_d.err_flags = 6'h00;
            r_d.error_source_channel = `ERROR_SOURCE_CHANNEL_RESET;
            r_d.result_ready_flag = 1'b0;
        end else if (result_read[r_q.error_source_channel] && (r_q.err_flags != 6'h00)) begin
            r_d.err_flags = 6'h00;
            r_d.error_source_channel = `ERROR_SOURCE_CHANNEL_RESET;
        end
        r_d.unread = r_d.unread & ~result_read;

        if (err_event != 6'h00) begin
            // Keep first source until cleared
            if (r_d.err_flags == 6'h00) begin
                r_d.error_source_channel = err_event_channel;
            end
            r_d.err_flags = r_d.err_flags | err_event;
        end

        if (conv_done) begin
            r_d.unread = r_d.unread | done_mask;
            if (!sequential_mode) begin
                r_d.result_ready_flag = 1'b1;
                r_d.seq_done = '0;
            end else if ((done_accum & active_channels) == active_channels) begin
                r_d.result_ready_flag = 1'b1;
                r_d.seq_done = '0;
            end else begin
                r_d.seq_done = done_accum;
            end
        end

        // Settling timer counts channel 3 reference ticks
        case (r_q.settle_st)
            sensor_divider_pkg::SETTLE_IDLE: begin
                if (settle_start) begin
                    r_d.settle_st = sensor_divider_pkg::SETTLE_RUN;
                    if (r_q.settle <= `SETTLE_SHORT_LIMIT) begin
                        r_d.settle_left = `SETTLE_MIN_TICKS;
                    end else begin
                        r_d.settle_left = 20'(r_q.settle) << `SETTLE_TICK_SHIFT;
                    end
                end
            end
            sensor_divider_pkg::SETTLE_RUN: begin
                if (ref_tick[NCH-1]) begin
                    if (r_q.settle_left == 20'h00001) begin
                        r_d.settle_left = 20'h00000;
                        r_d.settle_done = 1'b1;
                        r_d.settle_st = sensor_divider_pkg::SETTLE_IDLE;
                    end else begin
                        r_d.settle_left = r_q.settle_left - 20'h00001;
                    end
                end
            end
            default: r_d.settle_st = sensor_divider_pkg::SETTLE_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.div <= {NCH{`DIV_RESET}};
            r_q.settle <= `SETTLE_RESET;
            r_q.settle_st <= sensor_divider_pkg::SETTLE_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    assign reg_rdata = r_q.rdata;
    assign reg_rdata_valid = r_q.rvalid;
    assign settle_done = r_q.settle_done;

endmodule

`default_nettype wire

// *** verification/sdsr_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module sdsr_checker #(
    parameter int NCH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic [5:0] err_event,
    input wire logic conv_done,
    input wire logic [1:0] conv_channel,
    input wire logic sequential_mode,
    input wire logic [NCH-1:0] result_read,
    input wire logic settle_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic st = reg_rd_en && reg_addr == 8'h18;
    // No clearing read or source read between event and check
    sequence ev_rd;
        err_event != 6'h00 ##1 !st && result_read == '0 ##1 st;
    endsequence
    sequence quiet_rd;
        st && err_event == 6'h00 ##1 err_event == 6'h00 ##1 st;
    endsequence
    sequence conv_rd;
        conv_done && conv_channel == 2'h3 ##1 !result_read[3] ##1 st;
    endsequence
    sequence div_rd;
        reg_wr_en && reg_addr == 8'h14 ##1 !reg_wr_en ##1 reg_rd_en && reg_addr == 8'h14;
    endsequence
    a_read_answer: assert property (reg_rd_en |=> reg_rdata_valid)
        else $error("read not answered");
    a_valid_cause: assert property (reg_rdata_valid |-> $past(reg_rd_en))
        else $error("valid without read");
    a_reserved_zero: assert property (reg_rdata_valid && $past(reg_addr) == 8'h18 |->
        reg_rdata[7] == 1'b0 && reg_rdata[5:4] == 2'h0) else $error("reserved bit set");
    a_flags_seen: assert property (ev_rd |=>
        (reg_rdata[13:8] & $past(err_event, 3)) == $past(err_event, 3))
        else $error("error flag lost");
    a_read_clears: assert property (quiet_rd |=> reg_rdata[15:8] == 8'h00)
        else $error("error not cleared");
    a_unread_set: assert property (conv_rd |=> reg_rdata[0])
        else $error("unread flag missing");
    a_ready_single: assert property (!sequential_mode && conv_done ##1 !st ##1 st |=>
        reg_rdata[6]) else $error("ready missing");
    a_div_keep: assert property (div_rd |=> reg_rdata == $past(reg_wdata, 3))
        else $error("divider not kept");
    a_done_pulse: assert property (settle_done |=> !settle_done [*8])
        else $error("settle done too soon");
endmodule
////////////////////////////////////////
bind sensor_divider_status_regs sdsr_checker #(.NCH(NCH)) u_chk (
    .mclk, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
    .reg_rdata_valid, .err_event, .conv_done, .conv_channel, .sequential_mode,
    .result_read, .settle_done
);
`default_nettype wire

// *** verification/sensor_osc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sensor_osc_model (
    input wire logic mclk,
    input wire logic run,
    output logic [3:0] sensor_in
);
    logic [1:0] cnt = 2'h0;
    initial sensor_in = 4'h0;
    // 6.25 MHz, under the limit that forces a divider of two
    always @(negedge mclk) begin
        cnt <= run ? cnt + 2'h1 : 2'h0;
        sensor_in <= run ? {4{cnt[1]}} : 4'h0;
    end
endmodule
`default_nettype wire

// *** verification/tb_sensor_divider_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_sensor_divider_status_regs;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [5:0] err_event = 6'h00;
    logic [1:0] err_event_channel = 2'h0;
    logic conv_done = 1'b0;
    logic [1:0] conv_channel = 2'h0;
    logic sequential_mode = 1'b0;
    logic [3:0] active_channels = 4'h0;
    logic [3:0] result_read = 4'h0;
    logic settle_start = 1'b0;
    logic run = 1'b0;
    logic [15:0] reg_rdata;
    logic reg_rdata_valid, settle_done;
    logic [3:0] sensor_in, sensor_tick, ref_tick;
    int fail_count = 0;
    int checked = 0;
    always #20 mclk = ~mclk;
    sensor_osc_model i_osc (.mclk, .run, .sensor_in);
    sensor_divider_status_regs i_dut (.mclk, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en,
        .reg_wdata, .reg_rdata, .reg_rdata_valid, .err_event, .err_event_channel, .conv_done,
        .conv_channel, .sequential_mode, .active_channels, .result_read, .settle_start,
        .settle_done, .sensor_in, .sensor_tick, .ref_tick);
    ////////////////////////////////////////
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge mclk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rdc(input string w, input logic [7:0] a, input logic [15:0] e);
        @(negedge mclk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        chk("valid", 16'h0001, {15'h0000, reg_rdata_valid});
        chk(w, e, reg_rdata);
    endtask
    // One strobe cycle; channel feeds both error and conversion sides
    task automatic pulse(input logic [5:0] e, input logic [1:0] c, input logic d,
                         input logic [3:0] r);
        @(negedge mclk);
        err_event = e;
        err_event_channel = c;
        conv_channel = c;
        conv_done = d;
        result_read = r;
        @(negedge mclk);
        err_event = 6'h00;
        conv_done = 1'b0;
        result_read = 4'h0;
    endtask
    ////////////////////////////////////////
    task automatic reset_values;
        for (int a = 8'h13; a < 8'h19; a++) rdc("reset", 8'(a), 16'h0000);
        rdc("unmapped", 8'h30, 16'h0000);
        $display("reset values done");
    endtask
    task automatic error_flags;
        for (int k = 0; k < 6; k++) begin
            pulse(6'(1 << k), 2'(k), 1'b0, 4'h0);
            rdc("flag", 8'h18, {2'(k), 6'(1 << k), 8'h00});
            rdc("cleared", 8'h18, 16'h0000);
        end
        pulse(6'h01, 2'h2, 1'b0, 4'h0);
        pulse(6'h20, 2'h1, 1'b0, 4'h0);
        rdc("first", 8'h18, 16'hA100);
        pulse(6'h04, 2'h3, 1'b0, 4'h0);
        pulse(6'h00, 2'h0, 1'b0, 4'h2);
        rdc("other rd", 8'h18, 16'hC400);
        pulse(6'h04, 2'h3, 1'b0, 4'h0);
        pulse(6'h00, 2'h0, 1'b0, 4'h8);
        rdc("source rd", 8'h18, 16'h0000);
        $display("error flags done");
    endtask
    task automatic seq_ready;
        sequential_mode = 1'b1;
        active_channels = 4'h3;
        pulse(6'h00, 2'h0, 1'b1, 4'h0);
        rdc("partial", 8'h18, 16'h0008);
        pulse(6'h00, 2'h1, 1'b1, 4'h0);
        rdc("full", 8'h18, 16'h004C);
        rdc("ready clr", 8'h18, 16'h000C);
        pulse(6'h00, 2'h0, 1'b0, 4'hF);
        sequential_mode = 1'b0;
        $display("sequence ready done");
    endtask
    task automatic single_ready;
        for (int c = 0; c < 4; c++) pulse(6'h00, 2'(c), 1'b1, 4'h0);
        rdc("unread", 8'h18, 16'h004F);
        rdc("pending", 8'h18, 16'h000F);
        pulse(6'h00, 2'h0, 1'b0, 4'h5);
        rdc("taken", 8'h18, 16'h0005);
        pulse(6'h00, 2'h0, 1'b0, 4'hF);
        $display("single ready done");
    endtask
    task automatic divider_clocks;
        int r = 0;
        int s = 0;
        for (int c = 0; c < 4; c++) begin
            wr(8'(8'h14 + c), 16'h2003);
            rdc("div", 8'(8'h14 + c), 16'h2003);
        end
        wr(8'h18, 16'hFFFF);
        rdc("ro", 8'h18, 16'h0000);
        repeat (240) begin
            @(negedge mclk);
            // All four channels share one setting, so every tick output is watched
            r += $countones(ref_tick);
            s += $countones(sensor_tick);
        end
        chk("ref ticks", 16'h0140, 16'(r));
        chk("sensor ticks", 16'h0078, 16'(s));
        $display("divider clocks done");
    endtask
    task automatic settle_time;
        logic [15:0] cnt [3] = '{16'h0000, 16'h0001, 16'h0003};
        int n;
        int ex;
        wr(8'h17, 16'h1001);
        foreach (cnt[i]) begin
            ex = cnt[i] <= 16'h0001 ? 32 : cnt[i] * 16;
            wr(8'h13, cnt[i]);
            rdc("settle reg", 8'h13, cnt[i]);
            @(negedge mclk);
            settle_start = 1'b1;
            @(negedge mclk);
            settle_start = 1'b0;
            n = 1;
            while (settle_done !== 1'b1 && n < 400) begin
                @(negedge mclk);
                n++;
            end
            // Slack of a cycle or two for the registered tick path
            chk("settle", 16'h0001, 16'(n >= ex - 1 && n <= ex + 2));
        end
        $display("settle time done");
    endtask
    task automatic give_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        run = 1'b1;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        reset_values;
        error_flags;
        seq_ready;
        single_ready;
        divider_clocks;
        settle_time;
        give_verdict;
    end
    initial begin
        #200000;
        fail_count++;
        give_verdict;
    end
endmodule
`default_nettype wire
